// File: usp_pkg.sv
// Purpose: shared constants for the dual-channel serial pin and dma ready block
// Assumes: one core clock, two identical channels, fifo levels supplied by the uart core
// Notes: ready outputs are active low, serial lines idle high
//
// Overview of operation
// - Each channel's transmit pin is high during reset, when nothing is being sent, and when its transmitter is disabled.
// - In local loopback the transmit pin is disabled and the outgoing stream never reaches it.
// - In local loopback the receive pin is ignored and the outgoing stream is fed to the receiver.
// - In dma mode 0 receive-ready goes low when at least one received character is waiting to be read.
// - Receive-ready is high when the receive store is empty or, in dma mode 1, the trigger level is not yet reached.
// - Transmit-ready is low while the transmit store has at least one free location.
// - In dma mode 1 transmit-ready goes high once the transmit store has no free location.
// - Both ready outputs also pace single-character transfers in dma mode 0, not only block transfers.
// - Every pin and ready output exists once per channel and reflects only that channel.

package usp_pkg;
    localparam int unsigned USP_NUM_CH = 2;
    localparam int unsigned USP_FIFO_DEPTH = 128;
    localparam int unsigned USP_CNT_W = 8;
    localparam logic USP_LINE_IDLE = 1'b1;
    localparam logic USP_READY_ON = 1'b0;
    localparam logic USP_READY_OFF = 1'b1;
    localparam logic USP_DMA_MODE0 = 1'b0;
    localparam logic USP_DMA_MODE1 = 1'b1;
    localparam logic [USP_CNT_W-1:0] USP_CNT_EMPTY = 8'h00;
endpackage

// File: usp_sync_if.sv
// Purpose: carries one raw pin level into a synchroniser and the clean level back
// Assumes: raw comes from outside the core clock domain
// Notes: none

`timescale 1ns/1ps
`default_nettype none

interface usp_sync_if;
    logic raw;
    logic clean;
    modport sink (input raw, output clean);
    modport src (output raw, input clean);
endinterface // usp_sync_if

`default_nettype wire

// File: usp_pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for one serial pin
// Assumes: the pin idles high, so every stage resets to the idle level
// Notes: clean changes only when stages two and three agree

`timescale 1ns/1ps
`default_nettype none

module usp_pin_sync
    import usp_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // pin side and clean side
    usp_sync_if.sink sync
);
    logic meta;
    logic stage2;
    logic stage3;
    logic clean;

    // meta feeds stage2 only; nothing else may look at it
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta <= USP_LINE_IDLE;
            stage2 <= USP_LINE_IDLE;
            stage3 <= USP_LINE_IDLE;
        end else begin
            meta <= sync.raw;
            stage2 <= meta;
            stage3 <= stage2;
        end
    end

    // one-cycle glitches past stage2 are rejected
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            clean <= USP_LINE_IDLE;
        end else if (stage2 == stage3) begin
            clean <= stage3;
        end
    end

    assign sync.clean = clean;
endmodule // usp_pin_sync

`default_nettype wire

// File: usp_serial_dma_ready.sv
// Purpose: serial pin steering, local loopback and dma ready flags for two uart channels
// Assumes: the uart core supplies per-channel bit streams and fifo fill levels
// Notes: fill levels count characters held, 0 to the fifo depth inclusive

`timescale 1ns/1ps
`default_nettype none

module usp_serial_dma_ready
    import usp_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = USP_FIFO_DEPTH
)
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // channel 0 pins
    input wire logic serial_in_ch0_i,
    output logic serial_out_ch0_o,
    output logic rx_avail_n_ch0_o,
    output logic tx_space_n_ch0_o,
    // channel 1 pins
    input wire logic serial_in_ch1_i,
    output logic serial_out_ch1_o,
    output logic rx_avail_n_ch1_o,
    output logic tx_space_n_ch1_o,
    // channel 0 core side
    input wire logic tx_bit_ch0_i,
    input wire logic tx_active_ch0_i,
    input wire logic tx_enable_ch0_i,
    input wire logic loopback_ch0_i,
    input wire logic dma_mode_ch0_i,
    input wire logic [USP_CNT_W-1:0] rx_count_ch0_i,
    input wire logic [USP_CNT_W-1:0] rx_trigger_ch0_i,
    input wire logic [USP_CNT_W-1:0] tx_count_ch0_i,
    output logic rx_bit_ch0_o,
    // channel 1 core side
    input wire logic tx_bit_ch1_i,
    input wire logic tx_active_ch1_i,
    input wire logic tx_enable_ch1_i,
    input wire logic loopback_ch1_i,
    input wire logic dma_mode_ch1_i,
    input wire logic [USP_CNT_W-1:0] rx_count_ch1_i,
    input wire logic [USP_CNT_W-1:0] rx_trigger_ch1_i,
    input wire logic [USP_CNT_W-1:0] tx_count_ch1_i,
    output logic rx_bit_ch1_o
);
    // ----------------------------------------------------------------
    // per-channel packing
    // ----------------------------------------------------------------
    localparam logic [USP_CNT_W-1:0] FULL_LEVEL = USP_CNT_W'(FIFO_DEPTH);

    logic [USP_NUM_CH-1:0] tx_bit;
    logic [USP_NUM_CH-1:0] tx_active;
    logic [USP_NUM_CH-1:0] tx_enable;
    logic [USP_NUM_CH-1:0] loopback;
    logic [USP_NUM_CH-1:0] dma_mode;
    logic [USP_NUM_CH-1:0] pin_in;
    logic [USP_CNT_W-1:0] rx_count [USP_NUM_CH];
    logic [USP_CNT_W-1:0] rx_trigger [USP_NUM_CH];
    logic [USP_CNT_W-1:0] tx_count [USP_NUM_CH];
    logic [USP_NUM_CH-1:0] serial_out;
    logic [USP_NUM_CH-1:0] rx_bit;
    logic [USP_NUM_CH-1:0] rx_avail_n;
    logic [USP_NUM_CH-1:0] tx_space_n;
    logic [USP_NUM_CH-1:0] pin_clean;

    // each channel sees only its own inputs
    assign tx_bit = {tx_bit_ch1_i, tx_bit_ch0_i};
    assign tx_active = {tx_active_ch1_i, tx_active_ch0_i};
    assign tx_enable = {tx_enable_ch1_i, tx_enable_ch0_i};
    assign loopback = {loopback_ch1_i, loopback_ch0_i};
    assign dma_mode = {dma_mode_ch1_i, dma_mode_ch0_i};
    assign pin_in = {serial_in_ch1_i, serial_in_ch0_i};
    assign rx_count[0] = rx_count_ch0_i;
    assign rx_count[1] = rx_count_ch1_i;
    assign rx_trigger[0] = rx_trigger_ch0_i;
    assign rx_trigger[1] = rx_trigger_ch1_i;
    assign tx_count[0] = tx_count_ch0_i;
    assign tx_count[1] = tx_count_ch1_i;

    assign serial_out_ch0_o = serial_out[0];
    assign serial_out_ch1_o = serial_out[1];
    assign rx_bit_ch0_o = rx_bit[0];
    assign rx_bit_ch1_o = rx_bit[1];
    assign rx_avail_n_ch0_o = rx_avail_n[0];
    assign rx_avail_n_ch1_o = rx_avail_n[1];
    assign tx_space_n_ch0_o = tx_space_n[0];
    assign tx_space_n_ch1_o = tx_space_n[1];

    // ----------------------------------------------------------------
    // channel logic
    // ----------------------------------------------------------------
    for (genvar c = 0; c < USP_NUM_CH; c++) begin : g_ch
        usp_sync_if sync_bus ();
        logic tx_line;
        logic next_rx_avail_n;
        logic next_tx_space_n;

        assign sync_bus.raw = pin_in[c];
        assign pin_clean[c] = sync_bus.clean;

        usp_pin_sync u_sync (
            .core_clk_i (core_clk_i),
            .reset_i (reset_i),
            .sync (sync_bus.sink)
        );

        // internal stream idles high unless a character is really leaving
        assign tx_line = (tx_active[c] && tx_enable[c]) ? tx_bit[c] : USP_LINE_IDLE;

        // pin held idle in loopback so the far end sees a quiet line
        always_ff @(posedge core_clk_i or posedge reset_i) begin
            if (reset_i) begin
                serial_out[c] <= USP_LINE_IDLE;
            end else if (loopback[c]) begin
                serial_out[c] <= USP_LINE_IDLE;
            end else begin
                serial_out[c] <= tx_line;
            end
        end

        // receiver input: own stream in loopback, filtered pin otherwise
        always_ff @(posedge core_clk_i or posedge reset_i) begin
            if (reset_i) begin
                rx_bit[c] <= USP_LINE_IDLE;
            end else if (loopback[c]) begin
                rx_bit[c] <= tx_line;
            end else begin
                rx_bit[c] <= pin_clean[c]; // relies on idle-high far end
            end
        end

        // mode 0 paces per character, mode 1 waits for the trigger level
        always_comb begin
            next_rx_avail_n = USP_READY_OFF;
            if (rx_count[c] != USP_CNT_EMPTY) begin
                if (dma_mode[c] == USP_DMA_MODE0) begin
                    next_rx_avail_n = USP_READY_ON;
                end else if (rx_count[c] >= rx_trigger[c]) begin
                    next_rx_avail_n = USP_READY_ON;
                end
            end
        end

        // a full store never reports space, in either mode
        always_comb begin
            next_tx_space_n = USP_READY_OFF;
            if (tx_count[c] < FULL_LEVEL) begin
                next_tx_space_n = USP_READY_ON;
            end
        end

        always_ff @(posedge core_clk_i or posedge reset_i) begin
            if (reset_i) begin
                rx_avail_n[c] <= USP_READY_OFF;
                tx_space_n[c] <= USP_READY_OFF;
            end else begin
                rx_avail_n[c] <= next_rx_avail_n;
                tx_space_n[c] <= next_tx_space_n;
            end
        end

        // ------------------------------------------------------------
        // checks
        // ------------------------------------------------------------
        a_tx_idle_high: assert property (
            @(posedge core_clk_i) disable iff (reset_i)
            (!tx_active[c] || !tx_enable[c]) |=> serial_out[c] == USP_LINE_IDLE)
            else $error("transmit pin not idle high");

        a_tx_follows_stream: assert property (
            @(posedge core_clk_i) disable iff (reset_i)
            (tx_active[c] && tx_enable[c] && !loopback[c])
            |=> serial_out[c] == $past(tx_bit[c]))
            else $error("transmit pin does not follow stream");

        a_loop_pin_quiet: assert property (
            @(posedge core_clk_i) disable iff (reset_i)
            loopback[c] |=> serial_out[c] == USP_LINE_IDLE)
            else $error("stream leaked to pin in loopback");

        a_loop_feeds_rx: assert property (
            @(posedge core_clk_i) disable iff (reset_i)
            loopback[c] |=> rx_bit[c] == $past(tx_line))
            else $error("loopback stream not fed to receiver");

        a_pin_feeds_rx: assert property (
            @(posedge core_clk_i) disable iff (reset_i)
            !loopback[c] |=> rx_bit[c] == $past(pin_clean[c]))
            else $error("receiver not fed from pin");

        a_rx_avail_mode0: assert property (
            @(posedge core_clk_i) disable iff (reset_i)
            (dma_mode[c] == USP_DMA_MODE0 && rx_count[c] != USP_CNT_EMPTY)
            |=> rx_avail_n[c] == USP_READY_ON)
            else $error("receive ready missing in mode 0");

        a_rx_empty_off: assert property (
            @(posedge core_clk_i) disable iff (reset_i)
            rx_count[c] == USP_CNT_EMPTY |=> rx_avail_n[c] == USP_READY_OFF)
            else $error("receive ready low while empty");

        a_rx_below_trig: assert property (
            @(posedge core_clk_i) disable iff (reset_i)
            (dma_mode[c] == USP_DMA_MODE1 && rx_count[c] < rx_trigger[c])
            |=> rx_avail_n[c] == USP_READY_OFF)
            else $error("receive ready low below trigger");

        a_tx_space_on: assert property (
            @(posedge core_clk_i) disable iff (reset_i)
            tx_count[c] < FULL_LEVEL |=> tx_space_n[c] == USP_READY_ON)
            else $error("transmit ready high with space");

        a_tx_full_off: assert property (
            @(posedge core_clk_i) disable iff (reset_i)
            (dma_mode[c] == USP_DMA_MODE1 && tx_count[c] >= FULL_LEVEL)
            |=> tx_space_n[c] == USP_READY_OFF)
            else $error("transmit ready low while full");

        a_ready_one_cycle: assert property (
            @(posedge core_clk_i) disable iff (reset_i)
            $changed(rx_avail_n[c]) |-> $past(rx_count[c]) != $past(rx_count[c], 2)
                || $past(rx_trigger[c]) != $past(rx_trigger[c], 2)
                || $past(dma_mode[c]) != $past(dma_mode[c], 2)
                || $past(rx_avail_n[c]) != $past(next_rx_avail_n, 2))
            else $error("receive ready changed without cause");
    end
endmodule // usp_serial_dma_ready

`default_nettype wire

// File: usp_far_model.sv
// Purpose: remote serial sender standing on both receive pins
// Assumes: the bench commands when a line is pulled low
// Notes: no data pattern, only line levels

`timescale 1ns/1ps
`default_nettype none

module usp_far_model (
    // commands from the bench
    input wire logic [1:0] send_low_i,
    // receive pins of the block
    output logic serial_in_ch0_o,
    output logic serial_in_ch1_o
);
    // line rests high whenever no bit is being sent
    assign serial_in_ch0_o = ~send_low_i[0];
    assign serial_in_ch1_o = ~send_low_i[1];
endmodule // usp_far_model

`default_nettype wire

// File: usp_serial_dma_ready_test.sv
// Purpose: self-checking bench for serial pin steering and dma ready flags
// Assumes: inputs driven 1 ns after each rising edge
// Notes: ready flags judged one cycle after each change

`timescale 1ns/1ps
`default_nettype none

module usp_serial_dma_ready_test
    import usp_pkg::*;
;
    logic core_clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic [1:0] bt = 2'h3, act = 2'h0, en = 2'h0, lb = 2'h0, md = 2'h0, fs = 2'h0;
    logic [USP_CNT_W-1:0] rc0 = 8'h00, rc1 = 8'h00, rt0 = 8'h00, rt1 = 8'h00;
    logic [USP_CNT_W-1:0] tc0 = 8'h00, tc1 = 8'h00;
    wire logic so0, so1, ra0, ra1, ts0, ts1, rb0, rb1, si0, si1;
    int fail_count = 0;
    int samples_checked = 0;

    always #5 core_clk_i = ~core_clk_i;

    usp_far_model FAR (.send_low_i(fs), .serial_in_ch0_o(si0), .serial_in_ch1_o(si1));

    usp_serial_dma_ready DUT (
        .core_clk_i(core_clk_i), .reset_i(reset_i),
        .serial_in_ch0_i(si0), .serial_out_ch0_o(so0),
        .rx_avail_n_ch0_o(ra0), .tx_space_n_ch0_o(ts0),
        .serial_in_ch1_i(si1), .serial_out_ch1_o(so1),
        .rx_avail_n_ch1_o(ra1), .tx_space_n_ch1_o(ts1),
        .tx_bit_ch0_i(bt[0]), .tx_active_ch0_i(act[0]), .tx_enable_ch0_i(en[0]),
        .loopback_ch0_i(lb[0]), .dma_mode_ch0_i(md[0]), .rx_count_ch0_i(rc0),
        .rx_trigger_ch0_i(rt0), .tx_count_ch0_i(tc0), .rx_bit_ch0_o(rb0),
        .tx_bit_ch1_i(bt[1]), .tx_active_ch1_i(act[1]), .tx_enable_ch1_i(en[1]),
        .loopback_ch1_i(lb[1]), .dma_mode_ch1_i(md[1]), .rx_count_ch1_i(rc1),
        .rx_trigger_ch1_i(rt1), .tx_count_ch1_i(tc1), .rx_bit_ch1_o(rb1)
    );

    task automatic step(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic chk(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask

    task finish_test;
        if (fail_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset;
        step(1);
        chk("so0 in reset", 1'h1, so0);
        chk("so1 in reset", 1'h1, so1);
        chk("rx ready in reset", 1'h1, ra0 & ra1);
        chk("tx ready in reset", 1'h1, ts0 & ts1);
        chk("rx bits in reset", 1'h1, rb0 & rb1);
        step(1);
        reset_i = 1'h0;
        step(1);
    endtask

    task automatic test_tx;
        act = 2'h3; en = 2'h3; bt = 2'h2;
        step(1);
        chk("so0 data", 1'h0, so0);
        chk("so1 data", 1'h1, so1);
        bt = 2'h1;
        step(1);
        chk("so0 swap", 1'h1, so0);
        chk("so1 swap", 1'h0, so1);
        bt = 2'h0; en = 2'h2;
        step(1);
        chk("so0 disabled", 1'h1, so0);
        chk("so1 enabled", 1'h0, so1);
        en = 2'h3; act = 2'h2;
        step(1);
        chk("so0 idle", 1'h1, so0);
        act = 2'h3; lb = 2'h1;
        step(1);
        chk("so0 loopback", 1'h1, so0);
        chk("rb0 loopback", 1'h0, rb0);
        chk("so1 no loopback", 1'h0, so1);
        bt = 2'h3; act = 2'h0; lb = 2'h0;
        step(6);
    endtask

    task automatic test_rx;
        fs = 2'h2;
        // three stages, agree filter and receiver flop: level lands on the fifth edge
        step(5);
        chk("rb1 from pin", 1'h0, rb1);
        chk("rb0 untouched", 1'h1, rb0);
        lb = 2'h2;
        step(1);
        chk("rb1 pin ignored", 1'h1, rb1);
        fs = 2'h0; lb = 2'h0;
        step(5);
        chk("rb1 idle", 1'h1, rb1);
    endtask

    // one channel under test, the other left empty with free space
    task automatic rdy(input int c, input logic m, input logic [7:0] rc, tr, tc,
                       input logic ea, et);
        md = c ? {m, 1'h0} : {1'h0, m};
        rc0 = c ? 8'h00 : rc; rt0 = tr; tc0 = c ? 8'h00 : tc;
        rc1 = c ? rc : 8'h00; rt1 = tr; tc1 = c ? tc : 8'h00;
        step(1);
        chk("rx ready", ea, c ? ra1 : ra0);
        chk("tx ready", et, c ? ts1 : ts0);
        chk("other rx ready", 1'h1, c ? ra0 : ra1);
        chk("other tx ready", 1'h0, c ? ts0 : ts1);
    endtask

    task automatic test_ready;
        for (int c = 0; c < 2; c++) begin
            rdy(c, 1'h0, 8'h00, 8'h00, 8'h00, 1'h1, 1'h0);
            rdy(c, 1'h0, 8'h01, 8'h00, 8'h7F, 1'h0, 1'h0);
            rdy(c, 1'h1, 8'h03, 8'h04, 8'h80, 1'h1, 1'h1);
            rdy(c, 1'h1, 8'h04, 8'h04, 8'h7F, 1'h0, 1'h0);
            rdy(c, 1'h0, 8'h80, 8'h04, 8'h80, 1'h0, 1'h1);
            rdy(c, 1'h1, 8'h01, 8'h00, 8'h00, 1'h0, 1'h0);
        end
    endtask

    initial begin
        test_reset();
        test_tx();
        test_rx();
        test_ready();
        finish_test();
    end

    initial begin
        #100000;
        fail_count++;
        finish_test();
    end
endmodule // usp_serial_dma_ready_test

`default_nettype wire
